// file: rtl/led_driver_core.sv
// Driver end: shift chain, instruction decode, configuration and dimming generator
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "led_pwm_regs.svh"
module led_driver_core #(
  parameter int WDOG_CYCLES = `WDOG_TIME_MS * `REF_CLK_KHZ
) (
  input  wire logic        ref_clk,         // System clock
  input  wire logic        resetn,          // Synchronous reset, active low
  led_link_if.device       link,            // Serial link
  input  wire logic        rext_low,        // Reference pin comparator, async
  output logic [15:0]      channel_on,      // Sink enables per channel
  output logic [15:0]      config_word,     // Current configuration
  output logic [5:0]       gain_code,       // Global current gain
  output logic [1:0]       short_threshold, // Short detect threshold code
  output logic             low_power,       // Zero-data power save
  output logic             wdog_fault       // Grayscale clock stalled, sticky
);
  localparam logic [21:0] WDOG_LIMIT = 22'(WDOG_CYCLES);
  localparam logic [6:0]  OSC_LAST   = 7'(`OSC_HALF_CYCLES - 1);

  logic [4:0]  meta_reg, sync_reg, prev_reg;
  logic [15:0] shift_reg, shift_next;
  logic [3:0]  count_reg, count_next;
  logic [3:0]  latch_idx_reg, latch_idx_next;
  logic [15:0] hold_reg [16];
  logic [15:0] hold_next [16];
  logic [15:0] active_reg [16];
  logic [15:0] active_next [16];
  logic [`READ_CHAIN_BITS-1:0] chain_reg, chain_next;
  logic        read_mode_reg, read_mode_next;
  logic        pending_reg, pending_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] gs_reg, gs_next;
  logic [6:0]  osc_cnt_reg, osc_cnt_next;
  logic [21:0] wdog_cnt_reg, wdog_cnt_next;
  logic        wdog_seen_reg, wdog_seen_next;
  logic        sout_reg, sout_next;
  logic [15:0] on_reg, on_next;
  logic        low_power_reg, low_power_next;
  logic        sck_rise, lat_fall, gck_edge, stalled, all_high, all_zero;

  function automatic led_pwm_pkg::instr_t decode_instr(input logic [3:0] n);
    unique case (n[3:1])
      3'h0:    return led_pwm_pkg::INSTR_DATA_LATCH;
      3'h1:    return led_pwm_pkg::INSTR_GLOBAL;
      3'h3:    return led_pwm_pkg::INSTR_READ;
      3'h4:    return led_pwm_pkg::INSTR_NORMAL;
      3'h5:    return led_pwm_pkg::INSTR_WRITE_CFG;
      3'h6:    return led_pwm_pkg::INSTR_CNT_RESET;
      default: return led_pwm_pkg::INSTR_NONE;
    endcase
  endfunction

  // High counter bits pick the segment, low bits the slot inside it; each
  // segment is on for base slots, the remainder adds one slot to segments
  // taken in bit-reversed order so the extra pulses spread evenly
  function automatic logic dim_on(input logic [15:0] v, input logic [15:0] c,
                                  input logic plain, input logic wide);
    logic [9:0] slot;
    logic [9:0] base;
    logic [6:0] seg;
    logic [6:0] rem;
    logic [6:0] rev;
    slot = '0;
    base = '0;
    seg  = '0;
    rem  = '0;
    rev  = '0;
    if (plain)
      return c < v;
    if (wide)
    begin
      slot = {1'b0, c[8:0]};
      base = {1'b0, v[15:7]};
      seg  = c[15:9];
      rem  = v[6:0];
      for (int i = 0; i < 7; i++)
        rev[i] = seg[6 - i];
    end
    else
    begin
      slot = c[9:0];
      base = v[15:6];
      seg  = {1'b0, c[15:10]};
      rem  = {1'b0, v[5:0]};
      for (int i = 0; i < 6; i++)
        rev[i] = seg[5 - i];
    end
    return (slot < base) || ((slot == base) && (rev < rem));
  endfunction

  // Link pins and the comparator are asynchronous to ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= {link.shift_clock, link.serial_in, link.latch_strobe,
                   link.grayscale_clock, rext_low};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign sck_rise = sync_reg[4] & ~prev_reg[4];
  assign lat_fall = ~sync_reg[2] & prev_reg[2];

  always_comb
  begin
    shift_next     = shift_reg;
    count_next     = count_reg;
    latch_idx_next = latch_idx_reg;
    hold_next      = hold_reg;
    active_next    = active_reg;
    chain_next     = chain_reg;
    read_mode_next = read_mode_reg;
    pending_next   = pending_reg;
    cfg_next       = cfg_reg;
    gs_next        = gs_reg;
    osc_cnt_next   = osc_cnt_reg + 7'h01;
    wdog_cnt_next  = wdog_cnt_reg;
    wdog_seen_next = wdog_seen_reg;
    all_high       = 1'b1;
    all_zero       = 1'b1;
    if (sck_rise)
    begin
      if (sync_reg[2])
      begin
        if (count_reg != 4'hf)
          count_next = count_reg + 4'h1;
      end
      else if (read_mode_reg)
        chain_next = {chain_reg[`READ_CHAIN_BITS-2:0], sync_reg[3]};
      else
        shift_next = {shift_reg[14:0], sync_reg[3]};
    end
    // Both-edge grayscale clock, from pin or internal oscillator
    if (osc_cnt_reg == OSC_LAST)
      osc_cnt_next = '0;
    gck_edge = cfg_reg[`CFG_INT_OSC] ? (osc_cnt_reg == OSC_LAST)
                                     : (sync_reg[1] ^ prev_reg[1]);
    if (gck_edge)
    begin
      gs_next       = gs_reg + 16'h0001;
      wdog_cnt_next = '0;
    end
    else if (wdog_cnt_reg != WDOG_LIMIT)
      wdog_cnt_next = wdog_cnt_reg + 22'h000001;
    stalled = cfg_reg[`CFG_WDOG_EN] && (wdog_cnt_reg == WDOG_LIMIT);
    if (gck_edge && (gs_reg == 16'hffff) && pending_reg)
    begin
      active_next  = hold_reg;
      pending_next = 1'b0;
    end
    if (lat_fall)
    begin
      count_next = '0;
      unique case (decode_instr(count_reg))
        led_pwm_pkg::INSTR_DATA_LATCH:
        begin
          hold_next[4'hf - latch_idx_reg] = shift_reg;
          if (latch_idx_reg != 4'hf)
            latch_idx_next = latch_idx_reg + 4'h1;
        end
        led_pwm_pkg::INSTR_GLOBAL:
        begin
          if (!cfg_reg[`CFG_FORMAT])
            hold_next[0] = shift_reg;
          latch_idx_next = '0;
          if (cfg_reg[`CFG_IMMEDIATE])
          begin
            active_next  = hold_next;
            pending_next = 1'b0;
          end
          else
            pending_next = 1'b1;
        end
        led_pwm_pkg::INSTR_READ:
        begin
          for (int i = 0; i < 16; i++)
            chain_next[16 * i + 16 +: 16] = active_reg[i];
          chain_next[15:0] = cfg_reg;
          read_mode_next   = 1'b1;
          wdog_seen_next   = 1'b0;
        end
        led_pwm_pkg::INSTR_NORMAL:
          read_mode_next = 1'b0;
        led_pwm_pkg::INSTR_WRITE_CFG:
          cfg_next = shift_reg;
        led_pwm_pkg::INSTR_CNT_RESET:
        begin
          if (cfg_reg[`CFG_CNT_RST_EN])
            gs_next = '0;
        end
        default: ;
      endcase
    end
    if (stalled)
      wdog_seen_next = 1'b1;
    sout_next = read_mode_next ? chain_next[`READ_CHAIN_BITS-1] : shift_next[15];
    for (int i = 0; i < 16; i++)
    begin
      all_high = all_high & active_reg[i][15];
      all_zero = all_zero & (active_reg[i] == 16'h0000);
    end
    low_power_next = cfg_reg[`CFG_ZERO_SAVE] && all_zero;
    for (int i = 0; i < 16; i++)
      on_next[i] = dim_on(active_reg[i], gs_reg, cfg_reg[`CFG_PLAIN_PWM], all_high);
    // Protection forces every sink off
    if ((sync_reg[0] && !cfg_reg[`CFG_REXT_OFF]) || stalled || low_power_next)
      on_next = '0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      shift_reg     <= '0;
      count_reg     <= '0;
      latch_idx_reg <= '0;
      hold_reg      <= '{default: '0};
      active_reg    <= '{default: '0};
      chain_reg     <= '0;
      read_mode_reg <= 1'b0;
      pending_reg   <= 1'b0;
      cfg_reg       <= `CFG_RESET;
      gs_reg        <= '0;
      osc_cnt_reg   <= '0;
      wdog_cnt_reg  <= '0;
      wdog_seen_reg <= 1'b0;
      sout_reg      <= 1'b0;
      on_reg        <= '0;
      low_power_reg <= 1'b0;
    end
    else
    begin
      shift_reg     <= shift_next;
      count_reg     <= count_next;
      latch_idx_reg <= latch_idx_next;
      hold_reg      <= hold_next;
      active_reg    <= active_next;
      chain_reg     <= chain_next;
      read_mode_reg <= read_mode_next;
      pending_reg   <= pending_next;
      cfg_reg       <= cfg_next;
      gs_reg        <= gs_next;
      osc_cnt_reg   <= osc_cnt_next;
      wdog_cnt_reg  <= wdog_cnt_next;
      wdog_seen_reg <= wdog_seen_next;
      sout_reg      <= sout_next;
      on_reg        <= on_next;
      low_power_reg <= low_power_next;
    end
  end

  assign link.serial_out  = sout_reg;
  assign channel_on       = on_reg;
  assign config_word      = cfg_reg;
  assign gain_code        = cfg_reg[`CFG_GAIN_LSB +: 6];
  assign short_threshold  = cfg_reg[`CFG_THR_LSB +: 2];
  assign low_power        = low_power_reg;
  assign wdog_fault       = wdog_seen_reg;
endmodule // led_driver_core

// file: rtl/led_pwm_regs.svh
// Constants of the serial grayscale dimming link and its two ends
// Operation
// - zero or one pulses: capture data word
// - two or three pulses: global latch, new frame
// - six or seven pulses: load 272-bit readback
// - eight or nine pulses: leave readback mode
// - ten or eleven pulses: write configuration word
// - twelve or thirteen: clear counter if enabled
// - counter steps on both grayscale clock edges
// - bit 15 picks fifteen or sixteen latches
// - bit 14 low: low reference forces off
// - bit 13 picks internal grayscale oscillator
// - bit 12 picks density or plain PWM
// - bit 10 picks frame-end or immediate update
// - bits 9..4 gain code, reset 101011
// - bits 3..2 short threshold, reset 00
// - bit 1: low power on all-zero data
// - bit 0: watchdog turns outputs off
// - grayscale words shift in MSB first
// - fifteen format: global latch captures channel 0
// - sixteen format: global latch only loads
// - all above half: 128 segments, else 64
// - controller supplies and counts grayscale clocks
// - readback data leaves on serial output
`ifndef LED_PWM_REGS_SVH
`define LED_PWM_REGS_SVH
`define REF_CLK_KHZ      125000
`define CFG_RESET        16'h02b0
`define CFG_FORMAT       15
`define CFG_REXT_OFF     14
`define CFG_INT_OSC      13
`define CFG_PLAIN_PWM    12
`define CFG_CNT_RST_EN   11
`define CFG_IMMEDIATE    10
`define CFG_GAIN_LSB     4
`define CFG_THR_LSB      2
`define CFG_ZERO_SAVE    1
`define CFG_WDOG_EN      0
`define WDOG_TIME_MS     30
`define OSC_FREQ_KHZ     1500
`define OSC_HALF_CYCLES  (`REF_CLK_KHZ / (2 * `OSC_FREQ_KHZ))
`define READ_CHAIN_BITS  272
`define SCK_HALF_CYCLES  4
`define GCK_HALF_CYCLES  4
`define ADDR_TX_DATA     8'h00
`define ADDR_INSTR       8'h04
`define ADDR_STATUS      8'h08
`define ADDR_RX_DATA     8'h0c
`define ADDR_GCK_CTRL    8'h10
`define ADDR_GCK_COUNT   8'h14
`endif

// file: rtl/led_pwm_pkg.sv
// Types shared by both ends of the dimming link
package led_pwm_pkg;
  typedef enum logic [2:0] {
    INSTR_DATA_LATCH, INSTR_GLOBAL, INSTR_READ, INSTR_NORMAL,
    INSTR_WRITE_CFG, INSTR_CNT_RESET, INSTR_NONE
  } instr_t;
  typedef enum {HOST_IDLE, HOST_SHIFT, HOST_LATCH} host_state_t;
endpackage

// file: rtl/led_link_if.sv
// Four-wire serial link plus grayscale clock between controller and driver
interface led_link_if;
  logic shift_clock;     // Data shift clock
  logic serial_in;       // Data into the driver
  logic latch_strobe;    // Instruction window
  logic grayscale_clock; // Dimming clock, both edges count
  logic serial_out;      // Cascade data from the driver
  modport device (input shift_clock, serial_in, latch_strobe, grayscale_clock,
                  output serial_out);
  modport controller (output shift_clock, serial_in, latch_strobe, grayscale_clock,
                      input serial_out);
endinterface

// file: rtl/led_controller.sv
// Controller end: register port, word shifter, instruction pulses, grayscale clock
`include "led_pwm_regs.svh"
module led_controller (
  input  wire logic        ref_clk, // System clock
  input  wire logic        resetn,  // Synchronous reset, active low
  led_link_if.controller   link,    // Serial link
  input  wire logic [7:0]  addr,    // Register byte address
  input  wire logic [15:0] wr_data, // Write data
  input  wire logic        wr_en,   // Write strobe
  input  wire logic        rd_en,   // Read strobe
  output logic [15:0]      rd_data  // Read data, cycle after strobe
);
  localparam logic [2:0] SCK_LAST = 3'(`SCK_HALF_CYCLES - 1);
  localparam logic [2:0] GCK_LAST = 3'(`GCK_HALF_CYCLES - 1);

  led_pwm_pkg::host_state_t state_reg, state_next;
  logic [1:0]  sout_sync_reg;
  logic [15:0] tx_reg, tx_next;
  logic [15:0] rx_reg, rx_next;
  logic [2:0]  div_reg, div_next;
  logic [5:0]  step_reg, step_next;
  logic [5:0]  last_reg, last_next;
  logic        sck_reg, sck_next;
  logic        sin_reg, sin_next;
  logic        lat_reg, lat_next;
  logic        gck_run_reg, gck_run_next;
  logic        gck_reg, gck_next;
  logic [2:0]  gck_div_reg, gck_div_next;
  logic [15:0] gck_count_reg, gck_count_next;
  logic [15:0] rd_reg, rd_next;
  logic        tick;

  always_comb
  begin
    state_next     = state_reg;
    tx_next        = tx_reg;
    rx_next        = rx_reg;
    div_next       = div_reg + 3'h1;
    step_next      = step_reg;
    last_next      = last_reg;
    sck_next       = sck_reg;
    sin_next       = sin_reg;
    lat_next       = lat_reg;
    gck_run_next   = gck_run_reg;
    gck_next       = gck_reg;
    gck_div_next   = gck_div_reg + 3'h1;
    gck_count_next = gck_count_reg;
    rd_next        = '0;
    tick           = (div_reg == SCK_LAST);
    if (tick)
      div_next = '0;
    unique case (state_reg)
      led_pwm_pkg::HOST_IDLE:
      begin
        div_next  = '0;
        step_next = '0;
        if (wr_en && (addr == `ADDR_TX_DATA))
        begin
          tx_next    = wr_data;
          sin_next   = wr_data[15];
          state_next = led_pwm_pkg::HOST_SHIFT;
        end
        else if (wr_en && (addr == `ADDR_INSTR))
        begin
          last_next  = {1'b0, wr_data[3:0], 1'b0};
          lat_next   = 1'b1;
          state_next = led_pwm_pkg::HOST_LATCH;
        end
      end
      led_pwm_pkg::HOST_SHIFT:
        if (tick)
        begin
          step_next = step_reg + 6'h01;
          if (!step_reg[0])
          begin
            sck_next = 1'b1;
            rx_next  = {rx_reg[14:0], sout_sync_reg[1]};
          end
          else
          begin
            sck_next = 1'b0;
            tx_next  = {tx_reg[14:0], 1'b0};
            sin_next = tx_reg[14];
            if (step_reg == 6'h1f)
              state_next = led_pwm_pkg::HOST_IDLE;
          end
        end
      led_pwm_pkg::HOST_LATCH:
        if (tick)
        begin
          step_next = step_reg + 6'h01;
          if (step_reg == last_reg)
          begin
            lat_next   = 1'b0;
            state_next = led_pwm_pkg::HOST_IDLE;
          end
          else
            sck_next = ~step_reg[0];
        end
    endcase
    if (wr_en && (addr == `ADDR_GCK_CTRL))
      gck_run_next = wr_data[0];
    if (!gck_run_reg)
      gck_div_next = '0;
    else if (gck_div_reg == GCK_LAST)
    begin
      gck_div_next   = '0;
      gck_next       = ~gck_reg;
      gck_count_next = gck_count_reg + 16'h0001;
    end
    if (rd_en)
      unique case (addr)
        `ADDR_STATUS:    rd_next = {14'h0000, gck_run_reg,
                                    state_reg != led_pwm_pkg::HOST_IDLE};
        `ADDR_RX_DATA:   rd_next = rx_reg;
        `ADDR_GCK_CTRL:  rd_next = {15'h0000, gck_run_reg};
        `ADDR_GCK_COUNT: rd_next = gck_count_reg;
        default:         rd_next = '0;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg     <= led_pwm_pkg::HOST_IDLE;
      sout_sync_reg <= '0;
      tx_reg        <= '0;
      rx_reg        <= '0;
      div_reg       <= '0;
      step_reg      <= '0;
      last_reg      <= '0;
      sck_reg       <= 1'b0;
      sin_reg       <= 1'b0;
      lat_reg       <= 1'b0;
      gck_run_reg   <= 1'b0;
      gck_reg       <= 1'b0;
      gck_div_reg   <= '0;
      gck_count_reg <= '0;
      rd_reg        <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      sout_sync_reg <= {sout_sync_reg[0], link.serial_out};
      tx_reg        <= tx_next;
      rx_reg        <= rx_next;
      div_reg       <= div_next;
      step_reg      <= step_next;
      last_reg      <= last_next;
      sck_reg       <= sck_next;
      sin_reg       <= sin_next;
      lat_reg       <= lat_next;
      gck_run_reg   <= gck_run_next;
      gck_reg       <= gck_next;
      gck_div_reg   <= gck_div_next;
      gck_count_reg <= gck_count_next;
      rd_reg        <= rd_next;
    end
  end

  assign link.shift_clock     = sck_reg;
  assign link.serial_in       = sin_reg;
  assign link.latch_strobe    = lat_reg;
  assign link.grayscale_clock = gck_reg;
  assign rd_data              = rd_reg;
endmodule // led_controller

// file: testbench/led_grayscale_serial_pwm_chk.sv
// Checker for the serial dimming link between controller and driver
module led_grayscale_serial_pwm_chk (
  input wire logic ref_clk,         // System clock
  input wire logic resetn,          // Synchronous reset, active low
  input wire logic shift_clock,     // Data shift clock
  input wire logic serial_in,       // Data into the driver
  input wire logic latch_strobe,    // Instruction window
  input wire logic grayscale_clock, // Dimming clock
  input wire logic serial_out       // Cascade data from the driver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sck_prev_reg;
  logic [4:0] pulse_reg;
  logic [4:0] pulse_next;

  // Rising shift edges seen inside the current latch window
  always_comb
  begin
    pulse_next = latch_strobe ? pulse_reg : 5'h00;
    if (latch_strobe && shift_clock && !sck_prev_reg)
      pulse_next = pulse_reg + 5'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    sck_prev_reg <= resetn ? shift_clock : 1'b0;
    pulse_reg    <= resetn ? pulse_next : 5'h00;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sck_half_a: assert property ($changed(shift_clock) |=> $stable(shift_clock)[*3])
    else $error("shift clock phase shorter than four cycles");
  din_stable_a: assert property (shift_clock && !latch_strobe |-> $stable(serial_in))
    else $error("serial data moved while shift clock high");
  lat_rise_a: assert property ($rose(latch_strobe) |-> !shift_clock ##1 !shift_clock[*3])
    else $error("latch window opened too close to a shift pulse");
  lat_fall_a: assert property ($fell(latch_strobe) |-> !shift_clock && $past(shift_clock, 4) == 1'b0)
    else $error("latch window closed too close to a shift pulse");
  lat_clean_a: assert property (shift_clock |-> $stable(latch_strobe))
    else $error("latch strobe moved while shift clock high");
  lat_pulses_a: assert property (latch_strobe |-> pulse_reg <= 5'd15)
    else $error("more than fifteen pulses in one latch window");
  // Output may move after a rising shift edge or after any instruction window closes
  sout_move_a: assert property ($changed(serial_out) |-> shift_clock || $past(shift_clock)
      || $past(latch_strobe, 4) || $past(latch_strobe, 5) || $past(latch_strobe, 6))
    else $error("serial output moved without a shift edge");
  gck_half_a: assert property ($changed(grayscale_clock) |=> $stable(grayscale_clock)[*3])
    else $error("grayscale clock phase shorter than four cycles");

  cover property ($fell(latch_strobe) && pulse_reg == 5'd6);
  cover property ($fell(latch_strobe) && pulse_reg == 5'd13);
  cover property ($rose(grayscale_clock));
endmodule // led_grayscale_serial_pwm_chk

// file: testbench/led_grayscale_serial_pwm_tb.sv
// Self-checking bench: controller and driver joined over the serial dimming link
`include "led_pwm_regs.svh"
module led_grayscale_serial_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  n;
    logic [15:0] word;
    logic [15:0] exp;
  } row_t;
  logic        ref_clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data;
  logic        rext_low;
  logic [15:0] channel_on;
  logic [15:0] config_word;
  logic [5:0]  gain_code;
  logic [1:0]  short_threshold;
  logic        low_power;
  logic        wdog_fault;
  logic [15:0] cur_cfg;
  logic [15:0] v;
  int          bad_count;
  int          samples_checked;
  row_t        rows [5];

  led_link_if link_bus ();
  led_controller i_led_controller (.ref_clk(ref_clk), .resetn(resetn), .link(link_bus),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  // Short stall limit keeps the watchdog case brief
  led_driver_core #(.WDOG_CYCLES(200)) i_led_driver_core (.ref_clk(ref_clk), .resetn(resetn),
    .link(link_bus), .rext_low(rext_low), .channel_on(channel_on), .config_word(config_word),
    .gain_code(gain_code), .short_threshold(short_threshold), .low_power(low_power),
    .wdog_fault(wdog_fault));
  led_grayscale_serial_pwm_chk chk_link (.ref_clk(ref_clk), .resetn(resetn),
    .shift_clock(link_bus.shift_clock), .serial_in(link_bus.serial_in),
    .latch_strobe(link_bus.latch_strobe), .grayscale_clock(link_bus.grayscale_clock),
    .serial_out(link_bus.serial_out));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    // Launch on an edge so the strobe never moves mid-cycle
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
    @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    logic [15:0] s;
    for (int i = 0; i < 200; i++)
    begin
      rd(`ADDR_STATUS, s);
      if (s[0] === 1'b0)
        return;
    end
    bad_count++;
    $display("wrong value busy expected 0 seen 1");
  endtask

  task automatic send(input logic [15:0] w);
    wait_idle();
    wr(`ADDR_TX_DATA, w);
  endtask

  task automatic instr(input logic [3:0] n);
    wait_idle();
    wr(`ADDR_INSTR, {12'h000, n});
    wait_idle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [15:0] pix(input int k, input logic six);
    return (16'h1111 * 16'(k)) ^ (six ? 16'h0f0f : 16'h0000);
  endfunction

  // Channel 15 first; the decoy word before the sixteen-format global latch must not land
  task automatic load_frame(input logic six);
    for (int k = 15; k >= 0; k--)
    begin
      send(pix(k, six));
      instr((k == 0 && !six) ? 4'h2 : 4'(k % 2));
    end
    if (six)
    begin
      send(16'hbeef);
      instr(4'h3);
    end
  endtask

  task automatic readback(input logic six);
    instr({3'b011, six});
    for (int k = 15; k >= -1; k--)
    begin
      send(16'h0000);
      wait_idle();
      rd(`ADDR_RX_DATA, v);
      check("readback", (k < 0) ? cur_cfg : pix(k, six), v);
    end
    instr({3'b100, six});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    $display("wrong value run time expected end seen timeout");
    final_report();
  end

  initial
  begin
    resetn   = 1'b0;
    addr     = 8'h00;
    wr_data  = 16'h0000;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    rext_low = 1'b0;
    rows[0]  = '{4'ha, 16'h0004, 16'h0004};
    rows[1]  = '{4'hb, 16'h03f8, 16'h03f8};
    rows[2]  = '{4'h5, 16'h0000, 16'h03f8};
    rows[3]  = '{4'ha, 16'h8a9c, 16'h8a9c};
    rows[4]  = '{4'hb, 16'h9400, 16'h9400};
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("config", 16'h02b0, config_word);
    check("gain", 16'h002b, {10'h000, gain_code});
    check("threshold", 16'h0000, {14'h0000, short_threshold});
    check("outputs", 16'h0000, channel_on);
    check("flags", 16'h0000, {14'h0000, low_power, wdog_fault});
    rd(8'h20, v);
    check("unmapped", 16'h0000, v);
    $display("test reset done");
    foreach (rows[i])
    begin
      send(rows[i].word);
      instr(rows[i].n);
      check("config", rows[i].exp, config_word);
      check("gain", {10'h000, rows[i].exp[9:4]}, {10'h000, gain_code});
      check("threshold", {14'h0000, rows[i].exp[3:2]}, {14'h0000, short_threshold});
    end
    $display("test config rows done");
    cur_cfg = 16'h9400;
    load_frame(1'b1);
    readback(1'b1);
    send(16'h3c5a);
    send(16'ha5c3);
    wait_idle();
    rd(`ADDR_RX_DATA, v);
    check("cascade", 16'h3c5a, v);
    $display("test sixteen format done");
    cur_cfg = 16'h1400;
    send(cur_cfg);
    instr(4'ha);
    load_frame(1'b0);
    readback(1'b0);
    $display("test fifteen format done");
    // About 5000 counted edges: channel 1 (4369) has ended, channel 2 has not
    wr(`ADDR_GCK_CTRL, 16'h0001);
    repeat (20000) @(posedge ref_clk);
    #1;
    check("pwm", 16'hfffc, channel_on);
    instr(4'hc);
    check("no clear", 16'hfffc, channel_on);
    cur_cfg = 16'h1c00;
    send(cur_cfg);
    instr(4'hb);
    instr(4'hd);
    check("cleared", 16'hfffe, channel_on);
    // About 100 edges after the clear: channel 1 has used its slots in segment 0
    cur_cfg = 16'h0c00;
    send(cur_cfg);
    instr(4'hb);
    instr(4'hd);
    repeat (400) @(posedge ref_clk);
    #1;
    check("density", 16'hfffc, channel_on);
    $display("test pwm done");
    @(posedge ref_clk);
    rext_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    check("rext off", 16'h0000, channel_on);
    @(posedge ref_clk);
    rext_low <= 1'b0;
    cur_cfg = 16'h1c01;
    send(cur_cfg);
    instr(4'ha);
    wr(`ADDR_GCK_CTRL, 16'h0000);
    repeat (300) @(posedge ref_clk);
    #1;
    check("stall", 16'h0001, {15'h0000, wdog_fault});
    check("stall off", 16'h0000, channel_on);
    // Pin clock stopped: only the internal source can move the counter;
    // the deferred global latch must leave channel 0 dark
    cur_cfg = 16'h2800;
    send(cur_cfg);
    instr(4'hb);
    send(16'hffff);
    instr(4'h2);
    instr(4'hd);
    repeat (4000) @(posedge ref_clk);
    #1;
    check("oscillator", 16'hfffc, channel_on);
    $display("test protections done");
    final_report();
  end
endmodule // led_grayscale_serial_pwm_tb
